// File: verilog/meter_pkg.sv
package meter_pkg;

  // measurement functions
  typedef enum logic [2:0] {
    FN_DCV  = 3'h0,
    FN_ACV  = 3'h1,
    FN_OHM2 = 3'h2,
    FN_OHM4 = 3'h3,
    FN_DCI  = 3'h4,
    FN_ACI  = 3'h5
  } func_t;

  // range index, 0 is the lowest range of every function
  localparam logic [2:0] RNG_LO      = 3'h0;
  localparam logic [2:0] RNG_TOP_V   = 3'h3;  // .3V 3V 30V 300V
  localparam logic [2:0] RNG_TOP_OHM = 3'h5;  // 300 ohm .. 30M ohm
  localparam logic [2:0] RNG_TOP_DCI = 3'h0;  // 3A only
  localparam logic [2:0] RNG_TOP_ACI = 3'h1;  // 300mA 3A
  localparam logic [2:0] RNG_OHM_3M  = 3'h4;
  localparam logic [2:0] RNG_OHM_30M = 3'h5;
  localparam logic [2:0] RNG_OHM_3K  = 3'h1;
  localparam logic [2:0] RNG_OHM_30K = 3'h2;
  localparam logic [2:0] RNG_OHM_300K = 3'h3;

  // ohms source current setting
  typedef enum logic [2:0] {
    CUR_OFF   = 3'h0,
    CUR_1MA   = 3'h1,
    CUR_100UA = 3'h2,
    CUR_10UA  = 3'h3,
    CUR_1UA   = 3'h4,
    CUR_100NA = 3'h5
  } ohm_cur_t;

  // function field of the display
  typedef enum logic [2:0] {
    LBL_DC_VOLTS = 3'h0,
    LBL_AC_VOLTS = 3'h1,
    LBL_DC_AMPS  = 3'h2,
    LBL_AC_AMPS  = 3'h3,
    LBL_OHM      = 3'h4,
    LBL_KOHM     = 3'h5,
    LBL_MOHM     = 3'h6
  } label_t;

  // front panel key presses, one-cycle pulses
  typedef struct packed {
    logic dcVolts;
    logic acVolts;
    logic ohm2Wire;
    logic ohm4Wire;
    logic dcAmps;
    logic acAmps;
    logic upRange;
    logic downRange;
    logic autoManual;
    logic internalTrigger;
    logic singleTrigger;
  } keys_t;

  // display state
  typedef struct packed {
    label_t label;
    logic   twoWire;
    logic   fourWire;
    logic   manualRangeIndicator;
    logic   singleTriggerIndicator;
    logic   blankReading;
  } disp_t;

  // autorange points on the reading magnitude in display counts
  localparam int unsigned COUNT_W   = 17;
  localparam logic [16:0] UP_POINT   = 17'h0_7594;  // 30100
  localparam logic [16:0] DOWN_POINT = 17'h0_6978;  // 27000

  // settling waits
  localparam longint CLK_HZ         = 40000000;
  localparam longint AC_WAIT_MS     = 600;
  localparam longint OHM3M_WAIT_MS  = 20;
  localparam longint OHM30M_WAIT_MS = 200;
  localparam int AC_WAIT_CYC     = int'(AC_WAIT_MS * CLK_HZ / 1000);
  localparam int OHM3M_WAIT_CYC  = int'(OHM3M_WAIT_MS * CLK_HZ / 1000);
  localparam int OHM30M_WAIT_CYC = int'(OHM30M_WAIT_MS * CLK_HZ / 1000);
  localparam int WAIT_W          = 32;

  // measurement sequencer
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_t;

endpackage

// File: verilog/meter_range_trigger_control.sv
// Contract
// - dc volts: four ranges .3V to 300V
// - ac volts: same four ranges
// - resistance: six decade ranges 300 to 30M
// - source current setting per resistance range
// - two or four wire from pressed key
// - dc current: single 3A range
// - ac current: 300mA and 3A ranges
// - function label for volts and amps
// - ohm label by range, wire annunciator
// - ac volts: 0.6 s wait, also after range change
// - 3M and 30M ohm settling waits
// - manual ranging on keys, indicator lit
// - up key steps up, saturates at top
// - function change clamps to new top
// - down key steps down, saturates at bottom
// - function change clamps to new bottom
// - autorange at reset, auto/manual key toggles
// - autorange points 30100 up, 27000 down
// - internal trigger: back to back cycles
// - single key starts one cycle, sets mode
// - single key mid cycle restarts cycle
// - single mode change blanks until reading, except on an autorange step
// - reset state dc volts with autorange
module meter_range_trigger_control #(
  parameter int AC_WAIT_CYCLES     = meter_pkg::AC_WAIT_CYC,
  parameter int OHM3M_WAIT_CYCLES  = meter_pkg::OHM3M_WAIT_CYC,
  parameter int OHM30M_WAIT_CYCLES = meter_pkg::OHM30M_WAIT_CYC
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // front panel
  input  wire meter_pkg::keys_t               keys,
  output meter_pkg::disp_t                    display,
  // analog front end setting
  output meter_pkg::func_t                    measFunc,
  output logic [2:0]                          range,
  output meter_pkg::ohm_cur_t                 ohmCurrent,
  // converter
  output logic                                convStart,
  output logic                                convAbort,
  input  wire logic                           convDone,
  input  wire logic [meter_pkg::COUNT_W-1:0]  convCount,
  // finished readings
  output logic                                readingValid,
  output logic [meter_pkg::COUNT_W-1:0]       readingCount
);

  function automatic logic [2:0] topRange(input meter_pkg::func_t f);
    case (f)
      meter_pkg::FN_DCV:  topRange = meter_pkg::RNG_TOP_V;
      meter_pkg::FN_ACV:  topRange = meter_pkg::RNG_TOP_V;
      meter_pkg::FN_OHM2: topRange = meter_pkg::RNG_TOP_OHM;
      meter_pkg::FN_OHM4: topRange = meter_pkg::RNG_TOP_OHM;
      meter_pkg::FN_DCI:  topRange = meter_pkg::RNG_TOP_DCI;
      meter_pkg::FN_ACI:  topRange = meter_pkg::RNG_TOP_ACI;
      default:            topRange = meter_pkg::RNG_LO;
    endcase
  endfunction

  function automatic logic isOhms(input meter_pkg::func_t f);
    isOhms = (f == meter_pkg::FN_OHM2) || (f == meter_pkg::FN_OHM4);
  endfunction

  // settling wait before a reading; fresh marks a new function or range
  function automatic logic [meter_pkg::WAIT_W-1:0] waitFor(
    input meter_pkg::func_t f, input logic [2:0] r, input logic fresh);
    waitFor = '0;
    if (f == meter_pkg::FN_ACV && fresh) begin
      waitFor = meter_pkg::WAIT_W'(AC_WAIT_CYCLES);
    end else if (isOhms(f) && r == meter_pkg::RNG_OHM_3M) begin
      waitFor = meter_pkg::WAIT_W'(OHM3M_WAIT_CYCLES);
    end else if (isOhms(f) && r == meter_pkg::RNG_OHM_30M) begin
      waitFor = meter_pkg::WAIT_W'(OHM30M_WAIT_CYCLES);
    end
  endfunction

  meter_pkg::func_t               func_ff;
  meter_pkg::func_t               nxt_func;
  logic [2:0]                     rng_ff;
  logic [2:0]                     nxt_rng;
  logic                           auto_ff;
  logic                           single_ff;
  logic                           blank_ff;
  logic                           acFresh_ff;
  meter_pkg::seq_t                state_ff;
  logic [meter_pkg::WAIT_W-1:0]   wait_ff;
  logic                           autoUp;
  logic                           autoDown;
  logic                           funcKey;
  logic                           changed;
  logic                           doneNow;
  logic                           publish;

  assign doneNow = (state_ff == meter_pkg::ST_CONV) && convDone;
  // autorange steps only on a finished reading and never past the span
  assign autoUp = auto_ff && doneNow && (convCount >= meter_pkg::UP_POINT) &&
                  (rng_ff < topRange(func_ff));
  assign autoDown = auto_ff && doneNow && (convCount <= meter_pkg::DOWN_POINT) &&
                    (rng_ff > meter_pkg::RNG_LO);
  // any function key; when several land, the first in key order wins
  assign funcKey = keys.dcVolts | keys.acVolts | keys.ohm2Wire |
                   keys.ohm4Wire | keys.dcAmps | keys.acAmps;

  // next function and range from keys and autorange
  always_comb begin
    nxt_func = func_ff;
    nxt_rng = rng_ff;
    if (funcKey) begin
      if (keys.dcVolts) nxt_func = meter_pkg::FN_DCV;
      else if (keys.acVolts) nxt_func = meter_pkg::FN_ACV;
      else if (keys.ohm2Wire) nxt_func = meter_pkg::FN_OHM2;
      else if (keys.ohm4Wire) nxt_func = meter_pkg::FN_OHM4;
      else if (keys.dcAmps) nxt_func = meter_pkg::FN_DCI;
      else nxt_func = meter_pkg::FN_ACI;
      if (rng_ff > topRange(nxt_func)) nxt_rng = topRange(nxt_func);
      else if (rng_ff < meter_pkg::RNG_LO) nxt_rng = meter_pkg::RNG_LO;
    end else if (keys.upRange) begin
      if (rng_ff < topRange(func_ff)) nxt_rng = rng_ff + 3'h1;
    end else if (keys.downRange) begin
      if (rng_ff > meter_pkg::RNG_LO) nxt_rng = rng_ff - 3'h1;
    end else if (autoUp) begin
      nxt_rng = rng_ff + 3'h1;
    end else if (autoDown) begin
      nxt_rng = rng_ff - 3'h1;
    end
  end

  assign changed = (nxt_func != func_ff) || (nxt_rng != rng_ff);

  // function and range
  always_ff @(posedge clk) begin
    if (reset) begin
      func_ff <= meter_pkg::FN_DCV;
      rng_ff <= meter_pkg::RNG_LO;
    end else begin
      func_ff <= nxt_func;
      rng_ff <= nxt_rng;
    end
  end

  // range mode
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_ff <= 1'b1;
    end else if (keys.upRange || keys.downRange) begin
      auto_ff <= 1'b0;
    end else if (keys.autoManual) begin
      auto_ff <= ~auto_ff;
    end
  end

  // trigger mode
  // a single key wins over the internal key in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      single_ff <= 1'b0;
    end else if (keys.singleTrigger) begin
      single_ff <= 1'b1;
    end else if (keys.internalTrigger) begin
      single_ff <= 1'b0;
    end
  end

  // pending ac volts wait after a function or range change
  always_ff @(posedge clk) begin
    if (reset) begin
      acFresh_ff <= 1'b1;
    end else if (changed) begin
      acFresh_ff <= 1'b1;
    end else if (state_ff == meter_pkg::ST_SETTLE && wait_ff == '0) begin
      acFresh_ff <= 1'b0;
    end
  end

  // measurement sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= meter_pkg::ST_IDLE;
      wait_ff <= '0;
      convStart <= 1'b0;
      convAbort <= 1'b0;
    end else begin
      convStart <= 1'b0;
      convAbort <= 1'b0;
      // in single mode a change while idle only blanks; no cycle starts
      if (changed && !(single_ff && state_ff == meter_pkg::ST_IDLE)) begin
        // a reading still converting on the old setting is aborted
        convAbort <= (state_ff == meter_pkg::ST_CONV) && !convDone;
        state_ff <= meter_pkg::ST_SETTLE;
        wait_ff <= waitFor(nxt_func, nxt_rng, 1'b1);
      end else if (keys.singleTrigger) begin
        convAbort <= (state_ff == meter_pkg::ST_CONV) && !convDone;
        state_ff <= meter_pkg::ST_SETTLE;
        wait_ff <= waitFor(func_ff, rng_ff, acFresh_ff);
      end else begin
        case (state_ff)
          meter_pkg::ST_IDLE: begin
            if (!single_ff) begin
              state_ff <= meter_pkg::ST_SETTLE;
              wait_ff <= waitFor(func_ff, rng_ff, acFresh_ff);
            end
          end
          meter_pkg::ST_SETTLE: begin
            if (wait_ff == '0) begin
              convStart <= 1'b1;
              state_ff <= meter_pkg::ST_CONV;
            end else begin
              wait_ff <= wait_ff - meter_pkg::WAIT_W'(1);
            end
          end
          meter_pkg::ST_CONV: begin
            if (convDone) state_ff <= meter_pkg::ST_IDLE;
          end
          default: state_ff <= meter_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // a result that lands with a function, range or single key belongs to the old setting and is dropped
  assign publish = doneNow && !funcKey && !keys.upRange && !keys.downRange &&
                   !keys.singleTrigger;

  // reading output
  always_ff @(posedge clk) begin
    if (reset) begin
      readingValid <= 1'b0;
      readingCount <= '0;
    end else begin
      readingValid <= publish;
      if (publish) readingCount <= convCount;
    end
  end

  // blanking of the reading digits in single trigger mode
  always_ff @(posedge clk) begin
    if (reset) begin
      blank_ff <= 1'b0;
    end else if (publish) begin
      blank_ff <= 1'b0;
    end else if (single_ff && changed && !autoUp && !autoDown) begin
      blank_ff <= 1'b1;
    end
  end

  // front end setting follows the next function and range
  always_ff @(posedge clk) begin
    if (reset) begin
      measFunc <= meter_pkg::FN_DCV;
      range <= meter_pkg::RNG_LO;
    end else begin
      measFunc <= nxt_func;
      range <= nxt_rng;
    end
  end

  // ohms source current, off outside the resistance functions
  always_ff @(posedge clk) begin
    if (reset) begin
      ohmCurrent <= meter_pkg::CUR_OFF;
    end else if (!isOhms(nxt_func)) begin
      ohmCurrent <= meter_pkg::CUR_OFF;
    end else begin
      case (nxt_rng)
        meter_pkg::RNG_LO:       ohmCurrent <= meter_pkg::CUR_1MA;
        meter_pkg::RNG_OHM_3K:   ohmCurrent <= meter_pkg::CUR_1MA;
        meter_pkg::RNG_OHM_30K:  ohmCurrent <= meter_pkg::CUR_100UA;
        meter_pkg::RNG_OHM_300K: ohmCurrent <= meter_pkg::CUR_10UA;
        meter_pkg::RNG_OHM_3M:   ohmCurrent <= meter_pkg::CUR_1UA;
        default:                 ohmCurrent <= meter_pkg::CUR_100NA;
      endcase
    end
  end

  // display function field and annunciators
  always_ff @(posedge clk) begin
    if (reset) begin
      display <= '{label: meter_pkg::LBL_DC_VOLTS, default: 1'b0};
    end else begin
      case (nxt_func)
        meter_pkg::FN_DCV: display.label <= meter_pkg::LBL_DC_VOLTS;
        meter_pkg::FN_ACV: display.label <= meter_pkg::LBL_AC_VOLTS;
        meter_pkg::FN_DCI: display.label <= meter_pkg::LBL_DC_AMPS;
        meter_pkg::FN_ACI: display.label <= meter_pkg::LBL_AC_AMPS;
        default: begin
          if (nxt_rng <= meter_pkg::RNG_LO) display.label <= meter_pkg::LBL_OHM;
          else if (nxt_rng <= meter_pkg::RNG_OHM_300K) display.label <= meter_pkg::LBL_KOHM;
          else display.label <= meter_pkg::LBL_MOHM;
        end
      endcase
      display.twoWire <= (nxt_func == meter_pkg::FN_OHM2);
      display.fourWire <= (nxt_func == meter_pkg::FN_OHM4);
      display.manualRangeIndicator <= ~auto_ff;
      display.singleTriggerIndicator <= single_ff;
      display.blankReading <= blank_ff;
    end
  end

endmodule // meter_range_trigger_control

// File: dv/meter_exp.svh
function automatic logic [2:0] topOf(input meter_pkg::func_t f);
  if (f inside {meter_pkg::FN_DCV, meter_pkg::FN_ACV}) return 3'h3;
  if (isOhm(f)) return 3'h5;
  return (f == meter_pkg::FN_ACI) ? 3'h1 : 3'h0;
endfunction
function automatic logic isOhm(input meter_pkg::func_t f);
  return f inside {meter_pkg::FN_OHM2, meter_pkg::FN_OHM4};
endfunction
function automatic meter_pkg::ohm_cur_t curOf(input meter_pkg::func_t f, input logic [2:0] r);
  if (!isOhm(f)) return meter_pkg::CUR_OFF;
  return (r < 3'h2) ? meter_pkg::CUR_1MA : meter_pkg::ohm_cur_t'(r);
endfunction
function automatic meter_pkg::label_t lblOf(input meter_pkg::func_t f, input logic [2:0] r);
  if (isOhm(f)) return (r == 3'h0) ? meter_pkg::LBL_OHM : (r < 3'h4) ? meter_pkg::LBL_KOHM : meter_pkg::LBL_MOHM;
  if (f == meter_pkg::FN_DCV) return meter_pkg::LBL_DC_VOLTS;
  if (f == meter_pkg::FN_ACV) return meter_pkg::LBL_AC_VOLTS;
  return (f == meter_pkg::FN_DCI) ? meter_pkg::LBL_DC_AMPS : meter_pkg::LBL_AC_AMPS;
endfunction

// File: dv/front_end_model.sv
module front_end_model (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // converter control
  input  wire logic                          convStart,
  input  wire logic                          convAbort,
  input  wire logic [3:0]                    delay,
  input  wire logic [meter_pkg::COUNT_W-1:0] level,
  // converter result
  output logic                               convDone,
  output logic [meter_pkg::COUNT_W-1:0]      convCount
);
  logic [4:0] left_ff;
  always_ff @(posedge clk) begin
    if (reset) left_ff <= '0;
    else if (convStart) left_ff <= {1'b0, delay} + 5'h1;
    else if (convAbort) left_ff <= '0;
    else if (left_ff != '0) left_ff <= left_ff - 5'h1;
  end
  assign convDone = (left_ff == 5'h1);
  // count lines carry the inverted value outside the done cycle
  assign convCount = convDone ? level : ~level;
endmodule // front_end_model

// File: dv/meter_range_trigger_control_chk.sv
module meter_range_trigger_control_chk #(
  parameter int AC_WAIT_CYCLES     = 1,
  parameter int OHM3M_WAIT_CYCLES  = 1,
  parameter int OHM30M_WAIT_CYCLES = 1
) (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          reset,
  // panel
  input wire meter_pkg::keys_t              keys,
  input wire meter_pkg::disp_t              display,
  // front end
  input wire meter_pkg::func_t              measFunc,
  input wire logic [2:0]                    range,
  input wire meter_pkg::ohm_cur_t           ohmCurrent,
  // converter and finished readings
  input wire logic                          convStart,
  input wire logic                          convDone,
  input wire logic [meter_pkg::COUNT_W-1:0] convCount,
  input wire logic                          readingValid,
  input wire logic [meter_pkg::COUNT_W-1:0] readingCount
);
  `include "meter_exp.svh"
  int sinceChg_ff;
  int sinceRd_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset || measFunc != $past(measFunc) || range != $past(range)) sinceChg_ff <= 0;
    else if (sinceChg_ff < 1000) sinceChg_ff <= sinceChg_ff + 1;
  end
  always_ff @(posedge clk) begin
    if (reset || readingValid || measFunc != $past(measFunc) || range != $past(range)) sinceRd_ff <= 0;
    else if (sinceRd_ff < 1000) sinceRd_ff <= sinceRd_ff + 1;
  end
  a_range_span: assert property (range <= topOf(measFunc))
    else $error("range beyond function span");
  a_ohm_current: assert property (ohmCurrent == curOf(measFunc, range))
    else $error("wrong source current");
  a_label_map: assert property (display.label == lblOf(measFunc, range))
    else $error("wrong function label");
  a_wire_ann: assert property (display.twoWire == (measFunc == meter_pkg::FN_OHM2)
    && display.fourWire == (measFunc == meter_pkg::FN_OHM4)) else $error("wire annunciator wrong");
  a_up_step: assert property (keys.upRange && keys[10:5] == '0 |=> range ==
    (($past(range) == topOf(measFunc)) ? $past(range) : $past(range) + 3'h1)) else $error("up step wrong");
  a_down_step: assert property (keys.downRange && keys[10:4] == '0 |=> range ==
    (($past(range) == 3'h0) ? 3'h0 : $past(range) - 3'h1)) else $error("down step wrong");
  a_fn_clamp: assert property (keys[10:5] != '0 |=> range ==
    ((topOf(measFunc) < $past(range)) ? topOf(measFunc) : $past(range))) else $error("clamp wrong");
  a_manual_ind: assert property (keys.upRange || keys.downRange |-> ##2 display.manualRangeIndicator)
    else $error("manual indicator off");
  a_ac_wait: assert property (convStart && measFunc == meter_pkg::FN_ACV |-> sinceChg_ff >= AC_WAIT_CYCLES)
    else $error("ac start too early");
  a_ohm_wait: assert property (convStart && isOhm(measFunc) && range >= meter_pkg::RNG_OHM_3M |->
    sinceRd_ff >= ((range == meter_pkg::RNG_OHM_30M) ? OHM30M_WAIT_CYCLES : OHM3M_WAIT_CYCLES))
    else $error("ohm start too early");
  a_reading_pub: assert property (readingValid |-> $past(convDone) && readingCount == $past(convCount))
    else $error("reading not from converter");
  a_reset_state: assert property ($fell(reset) |-> measFunc == meter_pkg::FN_DCV && range == 3'h0
    && !display.manualRangeIndicator && !display.singleTriggerIndicator) else $error("reset state wrong");
  c_up: cover property (keys.upRange);
  c_read: cover property (readingValid ##1 range != $past(range));
  c_blank: cover property (display.blankReading);
  c_single: cover property (display.singleTriggerIndicator && convStart);
endmodule // meter_range_trigger_control_chk

bind meter_range_trigger_control meter_range_trigger_control_chk #(.AC_WAIT_CYCLES(AC_WAIT_CYCLES),
  .OHM3M_WAIT_CYCLES(OHM3M_WAIT_CYCLES), .OHM30M_WAIT_CYCLES(OHM30M_WAIT_CYCLES)) chk_u (.clk(clk),
  .reset(reset), .keys(keys), .display(display), .measFunc(measFunc), .range(range), .ohmCurrent(ohmCurrent),
  .convStart(convStart), .convDone(convDone), .convCount(convCount), .readingValid(readingValid),
  .readingCount(readingCount));

// File: dv/meter_range_trigger_control_tb_top.sv
module meter_range_trigger_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AC_W = 20;
  localparam int M3_W = 5;
  localparam int M30_W = 10;
  logic clk, reset, convStart, convAbort, convDone, readingValid;
  meter_pkg::keys_t keys;
  meter_pkg::disp_t display;
  meter_pkg::func_t fn, ef;
  meter_pkg::ohm_cur_t ohmCurrent;
  logic [2:0] range;
  logic [3:0] delay;
  logic [16:0] convCount, readingCount, level;
  int n_fail, comparisons, cycles, nStart, nAbort, er, n, s0, a0;
  int corner[15] = '{3, 4, 4, 4, 4, 8, 4, 4, 4, 9, 5, 6, 4, 7, 10};
  logic [16:0] pts[12] = '{17'h0_7594, 17'h0_7593, 17'h0_6979, 17'h0_7594, 17'h0_7594, 17'h0_7594,
    17'h0_7594, 17'h0_6978, 17'h0_6978, 17'h0_6978, 17'h0_6978, 17'h0_6978};
  `include "meter_exp.svh"
  meter_range_trigger_control #(.AC_WAIT_CYCLES(AC_W), .OHM3M_WAIT_CYCLES(M3_W), .OHM30M_WAIT_CYCLES(M30_W)) dut_u (
    .clk(clk), .reset(reset), .keys(keys), .display(display), .measFunc(fn), .range(range),
    .ohmCurrent(ohmCurrent), .convStart(convStart), .convAbort(convAbort), .convDone(convDone),
    .convCount(convCount), .readingValid(readingValid), .readingCount(readingCount));
  front_end_model fe_u (.clk(clk), .reset(reset), .convStart(convStart), .convAbort(convAbort),
    .delay(delay), .level(level), .convDone(convDone), .convCount(convCount));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (convStart === 1'b1) nStart++;
    if (convAbort === 1'b1) nAbort++;
    if (cycles == 20000) begin
      chk(1'b0, "timeout");
      conclude();
    end
  end
  // one-cycle key pulse, tracking the expected function and range
  task automatic press(input int b);
    @(negedge clk);
    keys = 11'h001 << b;
    if (b >= 5) ef = meter_pkg::func_t'(10 - b);
    if (b >= 5 && er > topOf(ef)) er = topOf(ef);
    if (b == 4 && er < topOf(ef)) er++;
    if (b == 3 && er > 0) er--;
    @(negedge clk);
    keys = '0;
  endtask
  task automatic chkState();
    chk(fn === ef && range === 3'(er), "function or range");
    chk(ohmCurrent === curOf(ef, 3'(er)), "source current");
    chk(display.label === lblOf(ef, 3'(er)) && display.twoWire === (ef == meter_pkg::FN_OHM2)
      && display.fourWire === (ef == meter_pkg::FN_OHM4), "display");
  endtask
  task automatic waitRd();
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (readingValid === 1'b1 && readingCount === level) break;
    end
    chk(i < 300, "no reading");
  endtask
  task automatic waitStart(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (convStart !== 1'b1 && k < 500);
  endtask
  initial begin
    keys = '0;
    reset = 1'b1;
    level = 17'h0_6D60;
    delay = 4'h3;
    ef = meter_pkg::FN_DCV;
    void'($urandom(32'h6319));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chkState();
    chk(display.manualRangeIndicator === 1'b0 && display.singleTriggerIndicator === 1'b0, "modes");
    foreach (corner[i]) begin
      press(corner[i]);
      chkState();
    end
    repeat (40) begin
      delay = 4'($urandom_range(15, 0));
      press(int'($urandom_range(10, 3)));
      chkState();
    end
    chk(display.manualRangeIndicator === 1'b1, "manual");
    $display("test ranging done");
    press(10);
    press(2);
    @(negedge clk);
    chk(display.manualRangeIndicator === 1'b0, "auto");
    foreach (pts[i]) begin
      level = pts[i];
      waitRd();
      if (level >= 17'h0_7594 && er < 3) er++;
      else if (level <= 17'h0_6978 && er > 0) er--;
      chk(range === 3'(er), "autorange");
    end
    level = 17'h0_6D60;
    $display("test autorange done");
    press(9);
    waitStart(n);
    chk(n > AC_W, "ac wait");
    press(4);
    waitStart(n);
    chk(n > AC_W, "ac range wait");
    press(8);
    repeat (4) press(4);
    waitStart(n);
    chk(n > M30_W, "30M wait");
    waitRd();
    waitStart(n);
    chk(n > M30_W, "30M reading wait");
    press(3);
    waitStart(n);
    chk(n > M3_W, "3M wait");
    $display("test settle done");
    delay = 4'hF;
    press(0);
    // the start pulse of the cycle this press cuts off is counted before here
    s0 = nStart;
    @(negedge clk);
    chk(display.singleTriggerIndicator === 1'b1, "single mode");
    repeat (150) @(negedge clk);
    chk(nStart - s0 == 1, "one cycle");
    s0 = nStart;
    a0 = nAbort;
    press(0);
    waitStart(n);
    press(0);
    repeat (150) @(negedge clk);
    chk(nStart - s0 == 2 && nAbort - a0 == 1, "restart");
    press(4);
    repeat (2) @(negedge clk);
    chk(display.blankReading === 1'b1, "blank");
    level = 17'h0_6D61;
    press(0);
    waitRd();
    repeat (2) @(negedge clk);
    chk(display.blankReading === 1'b0, "unblank");
    press(1);
    @(negedge clk);
    chk(display.singleTriggerIndicator === 1'b0, "internal");
    s0 = nStart;
    repeat (200) @(negedge clk);
    chk(nStart - s0 > 2, "free run");
    $display("test trigger done");
    conclude();
  end
endmodule // meter_range_trigger_control_tb_top
